/* shared/soi_pkg.sv */
package soi_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned MIN_LOW_US     = 30;
	localparam int unsigned MIN_LOW_CYC    = MIN_LOW_US * CLK_MHZ;
	localparam int unsigned TX_PULSE_US    = 30;
	localparam int unsigned TX_PULSE_CYC   = TX_PULSE_US * CLK_MHZ;

	// ==========================================================
	// Register map
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_PWM_PER = 4'h4;
	localparam logic [3:0] ADDR_PWM_DUTY = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;

	localparam int unsigned CTRL_FUNC_LSB = 0;
	localparam int unsigned CTRL_INV_BIT  = 2;
	localparam int unsigned CTRL_OVAL_LSB = 3;
	localparam int unsigned CTRL_ON_BIT   = 5;
	localparam int unsigned CTRL_OFF_BIT  = 6;

	localparam int unsigned STAT_ON_BIT   = 0;
	localparam int unsigned STAT_LVL_BIT  = 1;
	localparam int unsigned STAT_PIN_BIT  = 2;

	localparam logic [15:0] PWM_PER_RST  = 16'h00c8;
	localparam logic [15:0] PWM_DUTY_RST = 16'h0064;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		SOI_FN_SYNC = 2'h0,
		SOI_FN_IN   = 2'h1,
		SOI_FN_OUT  = 2'h2
	} soi_func_t;

	typedef enum logic [1:0] {
		SOI_OV_ONE  = 2'h0,
		SOI_OV_ZERO = 2'h1,
		SOI_OV_PWM  = 2'h2
	} soi_oval_t;

	typedef struct packed {
		logic       oe;
		logic       out;
	} soi_pin_drv_t;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} soi_bus_req_t;

endpackage : soi_pkg

/* rtl/soi_pwm.sv */
`timescale 1ns/1ps
module soi_pwm
	import soi_pkg::*;
#(
	parameter int unsigned W = 16
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	// Settings
	input  wire logic [W-1:0] period,
	input  wire logic [W-1:0] duty,
	// Waveform
	output logic              pwm
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         pwm;
	} soi_pwm_st_t;

	soi_pwm_st_t st_reg;
	soi_pwm_st_t st_next;

	// ==========================================================
	// Counter
	// A period of zero holds the counter at zero, so the output stays high for any nonzero duty.
	always_comb begin
		st_next = st_reg;
		if (st_reg.cnt + W'(1) >= period) begin
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + W'(1);
		end
		st_next.pwm = (st_reg.cnt < duty);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pwm = st_reg.pwm;

	a_pwm_low_duty: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(duty == '0) && $stable(duty) |=> !pwm)
		else $error("pwm high with zero duty");

endmodule : soi_pwm

/* rtl/soi_line.sv */
`timescale 1ns/1ps
module soi_line
	import soi_pkg::*;
#(
	parameter int unsigned PWM_W   = 16,
	parameter int unsigned MIN_LOW = MIN_LOW_CYC,
	parameter int unsigned TX_LEN  = TX_PULSE_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Output switch requests from the front panel
	input  wire logic        sw_on_req,
	input  wire logic        sw_off_req,
	output logic             out_on,
	// Line pin
	input  wire logic        line_in,
	output logic             line_out,
	output logic             line_oe
);

	localparam int unsigned CW = 16;

	typedef struct packed {
		soi_func_t         func;
		logic              inv;
		soi_oval_t         oval;
		logic [PWM_W-1:0]  per;
		logic [PWM_W-1:0]  duty;
		logic              on;
		logic [1:0]        sync;
		logic [CW-1:0]     low_cnt;
		logic              accepted;
		logic [CW-1:0]     tx_cnt;
		logic [31:0]       rdata;
	} soi_st_t;

	soi_st_t st_reg;
	soi_st_t st_next;
	logic    pwm;
	logic    lvl;
	logic    rx_pulse;
	logic    off_evt;

	function automatic logic to_pin(input logic v, input logic inv);
		return inv ? v : ~v;
	endfunction : to_pin

	soi_pwm #(
		.W      (PWM_W)
	) u_pwm (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.period (st_reg.per),
		.duty   (st_reg.duty),
		.pwm    (pwm)
	);

	// ==========================================================
	// Line receive
	// The logical level is active high: asserted means the pin sits low,
	// or high when inverted. Our own pulse is masked so we never retrigger.
	assign lvl = st_reg.inv ? st_reg.sync[1] : ~st_reg.sync[1];
	assign rx_pulse = (st_reg.func == SOI_FN_SYNC) && lvl
		&& (st_reg.low_cnt == CW'(MIN_LOW - 1)) && !st_reg.accepted
		&& (st_reg.tx_cnt == '0);
	assign off_evt = st_reg.on
		&& (sw_off_req || (rx_pulse && !sw_on_req));

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[0], line_in};
		if (lvl) begin
			if (st_reg.low_cnt != CW'(MIN_LOW - 1)) begin
				st_next.low_cnt = st_reg.low_cnt + CW'(1);
			end
			if (rx_pulse) begin
				st_next.accepted = 1'b1;
			end
		end else begin
			st_next.low_cnt  = '0;
			st_next.accepted = 1'b0;
		end
		// While on, switch-off wins over on, and on wins over a received pulse; a pulse while off does nothing.
		if (off_evt) begin
			st_next.on = 1'b0;
		end else if (sw_on_req) begin
			st_next.on = 1'b1;
		end
		if (st_reg.tx_cnt != '0) begin
			st_next.tx_cnt = st_reg.tx_cnt - CW'(1);
		end else if (off_evt && (st_reg.func == SOI_FN_SYNC)) begin
			st_next.tx_cnt = CW'(TX_LEN);
		end
		st_next.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL: begin
					st_next.rdata[CTRL_FUNC_LSB +: 2] = st_reg.func;
					st_next.rdata[CTRL_INV_BIT]        = st_reg.inv;
					st_next.rdata[CTRL_OVAL_LSB +: 2] = st_reg.oval;
				end
				ADDR_PWM_PER: begin
					st_next.rdata[PWM_W-1:0] = st_reg.per;
				end
				ADDR_PWM_DUTY: begin
					st_next.rdata[PWM_W-1:0] = st_reg.duty;
				end
				ADDR_STATUS: begin
					st_next.rdata[STAT_ON_BIT]  = st_reg.on;
					st_next.rdata[STAT_LVL_BIT] = lvl;
					st_next.rdata[STAT_PIN_BIT] = st_reg.sync[1];
				end
				default: begin
					st_next.rdata = '0;
				end
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				ADDR_CTRL: begin
					st_next.func = soi_func_t'(reg_wdata[CTRL_FUNC_LSB +: 2]);
					st_next.inv  = reg_wdata[CTRL_INV_BIT];
					st_next.oval = soi_oval_t'(reg_wdata[CTRL_OVAL_LSB +: 2]);
				end
				ADDR_PWM_PER: begin
					st_next.per = reg_wdata[PWM_W-1:0];
				end
				ADDR_PWM_DUTY: begin
					st_next.duty = reg_wdata[PWM_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_reg      <= '0;
			st_reg.func <= SOI_FN_SYNC;
			st_reg.inv  <= 1'b0;
			st_reg.oval <= SOI_OV_ONE;
			st_reg.per  <= PWM_W'(PWM_PER_RST);
			st_reg.duty <= PWM_W'(PWM_DUTY_RST);
			st_reg.sync <= 2'h3;
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Pin drive
	// Sync mode drives only while a pulse is out, leaving the shared line
	// free for the other instrument the rest of the time.
	always_comb begin
		line_oe  = 1'b0;
		line_out = to_pin(1'b0, st_reg.inv);
		case (st_reg.func)
			SOI_FN_SYNC: begin
				line_oe  = (st_reg.tx_cnt != '0);
				line_out = to_pin(1'b1, st_reg.inv);
			end
			SOI_FN_OUT: begin
				line_oe = 1'b1;
				case (st_reg.oval)
					SOI_OV_ONE:  line_out = to_pin(1'b1, st_reg.inv);
					SOI_OV_ZERO: line_out = to_pin(1'b0, st_reg.inv);
					SOI_OV_PWM:  line_out = to_pin(pwm, st_reg.inv);
					default:     line_out = to_pin(1'b0, st_reg.inv);
				endcase
			end
			default: begin
				line_oe = 1'b0;
			end
		endcase
	end

	assign out_on    = st_reg.on;
	assign reg_rdata = st_reg.rdata;

	// ==========================================================
	// Checks
	default clocking cb_sys @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// A switch-off taken in sync mode while no pulse is out must show up as a pulse.
	sequence s_turn_off;
		out_on && sw_off_req && (st_reg.func == SOI_FN_SYNC)
		&& (st_reg.tx_cnt == '0);
	endsequence
	sequence s_pulse_out;
		line_oe && !out_on;
	endsequence

	a_tx_on_off: assert property (s_turn_off |=> s_pulse_out)
		else $error("no pulse after turn-off");
	a_rx_kill_on: assert property (
		rx_pulse && out_on |=> !out_on)
		else $error("received pulse did not turn off");
	a_rx_off_hold: assert property (
		rx_pulse && !out_on && !sw_on_req |=> !out_on)
		else $error("pulse changed off state");
	a_rx_no_tx: assert property (
		rx_pulse && !out_on |=> !line_oe)
		else $error("pulse while off was echoed");
	a_glitch_filter: assert property (
		rx_pulse |-> $past(lvl, 1) && $past(lvl, 2))
		else $error("pulse accepted without low level");
	a_pol_drive: assert property (
		line_oe && (st_reg.func == SOI_FN_OUT)
		&& (st_reg.oval == SOI_OV_ONE) |-> line_out == st_reg.inv)
		else $error("wrong level for logic one");
	a_input_float: assert property (
		st_reg.func == SOI_FN_IN |-> !line_oe)
		else $error("input mode drives the pin");
	a_reset_mode: assert property (
		$fell(sys_rst) |-> st_reg.func == SOI_FN_SYNC && !st_reg.inv)
		else $error("wrong mode after reset");
	a_rd_data: assert property (
		reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[0] == $past(out_on))
		else $error("status read mismatch");

endmodule : soi_line

/* bench/soi_peer.sv */
`timescale 1ns/1ps
module soi_peer (
	// Clock and shared line
	input  wire logic        sys_clk,
	input  wire logic        line,
	// Pulse request from the bench
	input  wire logic [15:0] send_len,
	input  wire logic        send,
	output logic             pull_low,
	output int               low_cnt
);
	int left = 0;
	initial pull_low = 1'b0;
	initial low_cnt = 0;
	// Open drain: it only pulls low, the pull-up gives the idle high.
	always @(posedge sys_clk) begin
		if (send) left = send_len;
		pull_low <= (left > 0);
		if (left > 0) left = left - 1;
		if (!line) low_cnt <= low_cnt + 1;
	end
endmodule : soi_peer

/* bench/test_sync_off_io_pin.sv */
`timescale 1ns/1ps
module test_sync_off_io_pin import soi_pkg::*;;
	logic        sys_clk = 1'b0, sys_rst = 1'b1, send = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, d, seed = 32'h7e4a;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, sw_on_req = 1'b0;
	logic        sw_off_req = 1'b0, out_on, line_out, line_oe, line, pull_low;
	logic [15:0] send_len = 16'h0;
	int          low_cnt, error_cnt = 0, total_checks = 0, exp_on = 0;
	int          n, p, du, hi;
	localparam int FILT_LEN = 8;
	localparam int TX_CYC   = 5;
	// The peer wins a clash, as an open-drain low would.
	assign line = pull_low ? 1'b0 : (line_oe ? line_out : 1'b1);
	initial forever #2.5 sys_clk = ~sys_clk;
	soi_line #(.MIN_LOW(FILT_LEN), .TX_LEN(TX_CYC))
		u_dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sw_on_req(sw_on_req), .sw_off_req(sw_off_req), .out_on(out_on),
		.line_in(line), .line_out(line_out), .line_oe(line_oe));
	soi_peer u_peer (.sys_clk(sys_clk), .line(line), .send_len(send_len),
		.send(send), .pull_low(pull_low), .low_cnt(low_cnt));
	// ==========================================================
	// Tasks
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift
	task automatic count_hi(input int k);
		hi = 0;
		repeat (k) begin
			tick(1);
			#1;
			if (line_out === 1'b1) hi++;
		end
	endtask : count_hi
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		// A free edge keeps back-to-back writes from driving the strobe twice.
		tick(1);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		tick(1);
	endtask : rd
	task automatic sw(input int on);
		if (on) sw_on_req <= 1'b1;
		else sw_off_req <= 1'b1;
		tick(1);
		sw_on_req <= 1'b0;
		sw_off_req <= 1'b0;
		exp_on = on;
		tick(1);
	endtask : sw
	// Only a pulse at least as long as the filter may turn the output off.
	task automatic pulse(input int len);
		send_len <= len[15:0];
		send <= 1'b1;
		tick(1);
		send <= 1'b0;
		tick(len + 8);
		if (len >= FILT_LEN) exp_on = 0;
		#1 chk(out_on, exp_on[0]);
		tick(1);
	endtask : pulse
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	// ==========================================================
	// Tests
	initial begin
		tick(20000);
		error_cnt++;
		conclude();
	end
	initial begin
		tick(3);
		sys_rst <= 1'b0;
		tick(1);
		rd(ADDR_CTRL); chk(d, 32'h0);
		rd(ADDR_PWM_PER); chk(d, {16'h0, PWM_PER_RST});
		rd(4'h1); chk(d, 32'h0);
		chk(line_oe, 1'b0);
		$display("reset test done");
		sw(1);
		n = low_cnt;
		sw(0);
		tick(12);
		chk(low_cnt - n, TX_CYC);
		chk(line_oe, 1'b0);
		sw(1);
		pulse(4);
		pulse(FILT_LEN - 1);
		pulse(FILT_LEN);
		sw(1);
		pulse(12);
		pulse(12);
		$display("sync test done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CTRL, (i[1] << 2) | (i[0] << 3) | 32'h2);
			tick(1);
			chk({line_oe, line_out}, {1'b1, i[1] ^ i[0]});
		end
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CTRL, (i << 2) | 32'h1);
			tick(4);
			rd(ADDR_STATUS); chk(d[2:1], {1'b1, i[0]});
			send_len <= 16'h0014;
			send <= 1'b1;
			tick(1);
			send <= 1'b0;
			tick(6);
			rd(ADDR_STATUS); chk(d[2:1], {1'b0, ~i[0]});
			chk(line_oe, 1'b0);
			tick(20);
		end
		seed = xorshift(seed);
		p = 8 + int'(seed[3:0]);
		du = 1 + int'(seed[11:4]) % (p - 1);
		wr(ADDR_PWM_PER, p);
		wr(ADDR_PWM_DUTY, du);
		wr(ADDR_CTRL, 32'h16);
		tick(4);
		count_hi(4 * p);
		chk(hi, 4 * du);
		wr(ADDR_PWM_DUTY, 32'h0);
		tick(4);
		count_hi(2 * p);
		chk(hi, 0);
		$display("output test done");
		sw(1);
		sys_rst <= 1'b1;
		tick(3);
		sys_rst <= 1'b0;
		exp_on = 0;
		tick(1);
		chk(out_on, exp_on[0]);
		chk(line_oe, 1'b0);
		rd(ADDR_CTRL);
		chk(d, 32'h0);
		$display("restart test done");
		conclude();
	end
endmodule : test_sync_off_io_pin
